// *** xy_transfer_pkg.sv ***
// Package for the parallel X and Y memory transfer slot decoder
package xy_transfer_pkg;

  // ==========================================================
  // Opcode layout
  // ==========================================================
  localparam int          OPCODE_W         = 16;
  localparam int          WORD_W           = 16;
  localparam int          REG_W            = 32;
  localparam int          ADDR_W           = 32;
  localparam logic [5:0]  SLOT_PREFIX      = 6'h3c;
  localparam int          PREFIX_HI        = 15;
  localparam int          PREFIX_LO        = 10;
  localparam int          X_PTR_BIT        = 9;
  localparam int          Y_PTR_BIT        = 8;
  localparam int          X_DATA_BIT       = 7;
  localparam int          Y_DATA_BIT       = 6;
  localparam int          X_DIR_BIT        = 5;
  localparam int          Y_DIR_BIT        = 4;
  localparam int          X_MODE_HI        = 3;
  localparam int          X_MODE_LO        = 2;
  localparam int          Y_MODE_HI        = 1;
  localparam int          Y_MODE_LO        = 0;

  // ==========================================================
  // Reset values and steps
  // ==========================================================
  localparam logic [REG_W-1:0]  REG_RESET   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PTR_STEP    = 32'h0000_0002;
  localparam logic [WORD_W-1:0] LOW_ZERO    = 16'h0000;
  localparam logic              FLAG_RESET  = 1'b0;

  typedef enum logic [1:0] {
    MODE_IDLE  = 2'h0,
    MODE_PLAIN = 2'h1,
    MODE_INC   = 2'h2,
    MODE_INDEX = 2'h3
  } addr_mode_type;

  // Decoded slot fields
  typedef struct packed {
    logic          active;
    logic          ptr_sel;
    logic          data_sel;
    logic          store;
    addr_mode_type mode;
  } slot_decode_type;

  // One memory port request
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_type;

endpackage : xy_transfer_pkg

// *** slot_decoder.sv ***
// Field decoder for one memory transfer slot
`timescale 1ns/1ns
module slot_decoder
  import xy_transfer_pkg::*;
#(
  parameter int PTR_BIT  = X_PTR_BIT,
  parameter int DATA_BIT = X_DATA_BIT,
  parameter int DIR_BIT  = X_DIR_BIT,
  parameter int MODE_HI  = X_MODE_HI,
  parameter int MODE_LO  = X_MODE_LO
) (
  input  wire logic [OPCODE_W-1:0] opcode, // Instruction word
  input  wire logic                valid,  // Instruction word present
  output slot_decode_type          dec     // Decoded slot
);

  logic prefix_ok;

  always_comb begin
    prefix_ok    = valid && (opcode[PREFIX_HI:PREFIX_LO] == SLOT_PREFIX);
    dec.ptr_sel  = opcode[PTR_BIT];
    dec.data_sel = opcode[DATA_BIT];
    dec.store    = opcode[DIR_BIT];
    dec.mode     = addr_mode_type'(opcode[MODE_HI:MODE_LO]);
    // Mode 00 is the idle slot: no access, nothing changes
    dec.active   = prefix_ok && (dec.mode != MODE_IDLE);
  end

endmodule : slot_decoder

// *** slot_pointer_unit.sv ***
// Address and pointer update for one memory transfer slot
`timescale 1ns/1ns
module slot_pointer_unit
  import xy_transfer_pkg::*;
(
  input  slot_decode_type   dec,       // Decoded slot
  input  wire logic [ADDR_W-1:0] ptr_lo, // Pointer for select 0
  input  wire logic [ADDR_W-1:0] ptr_hi, // Pointer for select 1
  input  wire logic [ADDR_W-1:0] step,   // Index step register
  output logic [ADDR_W-1:0] addr,      // Access address
  output logic [ADDR_W-1:0] ptr_next,  // Updated pointer value
  output logic              ptr_write  // Pointer must be written
);

  always_comb begin
    addr      = dec.ptr_sel ? ptr_hi : ptr_lo;
    ptr_next  = addr;
    ptr_write = 1'b0;
    case (dec.mode)
      MODE_INC: begin
        ptr_next  = addr + PTR_STEP;
        ptr_write = dec.active;
      end
      MODE_INDEX: begin
        ptr_next  = addr + step;
        ptr_write = dec.active;
      end
      default: begin
        ptr_next  = addr;
        ptr_write = 1'b0;
      end
    endcase
  end

endmodule : slot_pointer_unit

// *** dsp_xy_memory_transfer.sv ***
// Parallel X and Y memory transfer slots with their DSP registers
`timescale 1ns/1ns
module dsp_xy_memory_transfer
  import xy_transfer_pkg::*;
(
  input  wire logic                clk,           // Core clock
  input  wire logic                rst,           // Sync reset, high
  input  wire logic [OPCODE_W-1:0] opcode,        // Instruction word
  input  wire logic                opcode_valid,  // Word issued this cycle
  input  wire logic [WORD_W-1:0]   x_rdata,       // X memory read data
  input  wire logic [WORD_W-1:0]   y_rdata,       // Y memory read data
  input  wire logic [REG_W-1:0]    acc0,          // Accumulator A0
  input  wire logic [REG_W-1:0]    acc1,          // Accumulator A1
  input  wire logic [ADDR_W-1:0]   x_index_step,  // X index register
  input  wire logic [ADDR_W-1:0]   y_index_step,  // Y index register
  input  wire logic                flag_in,       // Condition flag in
  output mem_req_type              x_req,         // X memory request
  output mem_req_type              y_req,         // Y memory request
  output logic [ADDR_W-1:0]        ptr4,          // Pointer R4
  output logic [ADDR_W-1:0]        ptr5,          // Pointer R5
  output logic [ADDR_W-1:0]        ptr6,          // Pointer R6
  output logic [ADDR_W-1:0]        ptr7,          // Pointer R7
  output logic [REG_W-1:0]         x0_reg,        // Load target X0
  output logic [REG_W-1:0]         x1_reg,        // Load target X1
  output logic [REG_W-1:0]         y0_reg,        // Load target Y0
  output logic [REG_W-1:0]         y1_reg,        // Load target Y1
  output logic                     condition_flag // Flag, held across slots
);

  // ==========================================================
  // Decode
  // ==========================================================
  slot_decode_type   x_dec;
  slot_decode_type   y_dec;
  logic [ADDR_W-1:0] x_addr;
  logic [ADDR_W-1:0] y_addr;
  logic [ADDR_W-1:0] x_ptr_next;
  logic [ADDR_W-1:0] y_ptr_next;
  logic              x_ptr_write;
  logic              y_ptr_write;

  slot_decoder #(
    .PTR_BIT  (X_PTR_BIT),
    .DATA_BIT (X_DATA_BIT),
    .DIR_BIT  (X_DIR_BIT),
    .MODE_HI  (X_MODE_HI),
    .MODE_LO  (X_MODE_LO)
  ) u_x_dec (
    .opcode (opcode),
    .valid  (opcode_valid),
    .dec    (x_dec)
  );

  slot_decoder #(
    .PTR_BIT  (Y_PTR_BIT),
    .DATA_BIT (Y_DATA_BIT),
    .DIR_BIT  (Y_DIR_BIT),
    .MODE_HI  (Y_MODE_HI),
    .MODE_LO  (Y_MODE_LO)
  ) u_y_dec (
    .opcode (opcode),
    .valid  (opcode_valid),
    .dec    (y_dec)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  // Pointers R4 to R7
  logic [ADDR_W-1:0] ptr4_q;
  logic [ADDR_W-1:0] ptr4_d;
  logic [ADDR_W-1:0] ptr5_q;
  logic [ADDR_W-1:0] ptr5_d;
  logic [ADDR_W-1:0] ptr6_q;
  logic [ADDR_W-1:0] ptr6_d;
  logic [ADDR_W-1:0] ptr7_q;
  logic [ADDR_W-1:0] ptr7_d;
  // Load targets X0, X1, Y0, Y1
  logic [REG_W-1:0]  x0_q;
  logic [REG_W-1:0]  x0_d;
  logic [REG_W-1:0]  x1_q;
  logic [REG_W-1:0]  x1_d;
  logic [REG_W-1:0]  y0_q;
  logic [REG_W-1:0]  y0_d;
  logic [REG_W-1:0]  y1_q;
  logic [REG_W-1:0]  y1_d;
  // Memory requests and the pending load write-back
  mem_req_type       x_req_q;
  mem_req_type       x_req_d;
  mem_req_type       y_req_q;
  mem_req_type       y_req_d;
  logic              x_load_q;
  logic              x_load_d;
  logic              y_load_q;
  logic              y_load_d;
  logic              x_tgt_q;
  logic              x_tgt_d;
  logic              y_tgt_q;
  logic              y_tgt_d;
  // Condition flag
  logic              flag_q;
  logic              flag_d;
  // Combinational helpers
  logic [REG_W-1:0]  x_src;
  logic [REG_W-1:0]  y_src;
  logic [REG_W-1:0]  x_load_word;
  logic [REG_W-1:0]  y_load_word;

  // ==========================================================
  // Addressing
  // ==========================================================
  slot_pointer_unit u_x_ptr (
    .dec       (x_dec),
    .ptr_lo    (ptr4_q),
    .ptr_hi    (ptr5_q),
    .step      (x_index_step),
    .addr      (x_addr),
    .ptr_next  (x_ptr_next),
    .ptr_write (x_ptr_write)
  );

  slot_pointer_unit u_y_ptr (
    .dec       (y_dec),
    .ptr_lo    (ptr6_q),
    .ptr_hi    (ptr7_q),
    .step      (y_index_step),
    .addr      (y_addr),
    .ptr_next  (y_ptr_next),
    .ptr_write (y_ptr_write)
  );

  // ==========================================================
  // Pointer update
  // ==========================================================
  // Plain and idle modes leave the pointers alone. The slots own
  // disjoint pointers, so both can update on the same edge.
  always_comb begin
    ptr4_d = ptr4_q;
    ptr5_d = ptr5_q;
    ptr6_d = ptr6_q;
    ptr7_d = ptr7_q;
    if (x_ptr_write) begin
      if (x_dec.ptr_sel) begin
        ptr5_d = x_ptr_next;
      end else begin
        ptr4_d = x_ptr_next;
      end
    end
    if (y_ptr_write) begin
      if (y_dec.ptr_sel) begin
        ptr7_d = y_ptr_next;
      end else begin
        ptr6_d = y_ptr_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr4_q <= REG_RESET;
      ptr5_q <= REG_RESET;
      ptr6_q <= REG_RESET;
      ptr7_q <= REG_RESET;
    end else begin
      ptr4_q <= ptr4_d;
      ptr5_q <= ptr5_d;
      ptr6_q <= ptr6_d;
      ptr7_q <= ptr7_d;
    end
  end

  // ==========================================================
  // Load write-back
  // ==========================================================
  // Read data returns in the same cycle as the request, so the register
  // write-back trails the take by one cycle; a slot still issues
  // every cycle, back to back.
  always_comb begin
    x0_d        = x0_q;
    x1_d        = x1_q;
    y0_d        = y0_q;
    y1_d        = y1_q;
    x_load_word = {x_rdata, LOW_ZERO};
    y_load_word = {y_rdata, LOW_ZERO};
    if (x_load_q) begin
      if (x_tgt_q) begin
        x1_d = x_load_word;
      end else begin
        x0_d = x_load_word;
      end
    end
    if (y_load_q) begin
      if (y_tgt_q) begin
        y1_d = y_load_word;
      end else begin
        y0_d = y_load_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      x0_q <= REG_RESET;
      x1_q <= REG_RESET;
      y0_q <= REG_RESET;
      y1_q <= REG_RESET;
    end else begin
      x0_q <= x0_d;
      x1_q <= x1_d;
      y0_q <= y0_d;
      y1_q <= y1_d;
    end
  end

  // ==========================================================
  // Memory requests
  // ==========================================================
  // Load direction and target ride along one cycle so the
  // write-back knows where the returning word goes.
  always_comb begin
    x_src         = x_dec.data_sel ? acc1 : acc0;
    y_src         = y_dec.data_sel ? acc1 : acc0;
    x_req_d.valid = x_dec.active;
    x_req_d.write = x_dec.active && x_dec.store;
    x_req_d.addr  = x_addr;
    x_req_d.wdata = x_src[REG_W-1:REG_W-WORD_W];
    y_req_d.valid = y_dec.active;
    y_req_d.write = y_dec.active && y_dec.store;
    y_req_d.addr  = y_addr;
    y_req_d.wdata = y_src[REG_W-1:REG_W-WORD_W];
    x_load_d      = x_dec.active && !x_dec.store;
    y_load_d      = y_dec.active && !y_dec.store;
    x_tgt_d       = x_dec.data_sel;
    y_tgt_d       = y_dec.data_sel;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      x_req_q  <= '0;
      y_req_q  <= '0;
      x_load_q <= 1'b0;
      y_load_q <= 1'b0;
      x_tgt_q  <= 1'b0;
      y_tgt_q  <= 1'b0;
    end else begin
      x_req_q  <= x_req_d;
      y_req_q  <= y_req_d;
      x_load_q <= x_load_d;
      y_load_q <= y_load_d;
      x_tgt_q  <= x_tgt_d;
      y_tgt_q  <= y_tgt_d;
    end
  end

  // ==========================================================
  // Condition flag
  // ==========================================================
  // Transfer slots never touch the flag; it only follows its input
  // in cycles with no instruction issued.
  always_comb begin
    flag_d = flag_q;
    if (!opcode_valid) begin
      flag_d = flag_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign x_req          = x_req_q;
  assign y_req          = y_req_q;
  assign ptr4           = ptr4_q;
  assign ptr5           = ptr5_q;
  assign ptr6           = ptr6_q;
  assign ptr7           = ptr7_q;
  assign x0_reg         = x0_q;
  assign x1_reg         = x1_q;
  assign y0_reg         = y0_q;
  assign y1_reg         = y1_q;
  assign condition_flag = flag_q;

endmodule : dsp_xy_memory_transfer

// *** xy_slot_chk.sv ***
// Checker for the parallel X and Y transfer slots
`timescale 1ns/1ns
module xy_slot_chk
  import xy_transfer_pkg::*;
(
  input wire logic        clk,            // Clock
  input wire logic        rst,            // Reset
  input wire logic [15:0] opcode,         // Instruction
  input wire logic        opcode_valid,   // Issue
  input wire logic [15:0] x_rdata,        // X data
  input wire logic [31:0] acc0,           // A0
  input wire logic [31:0] acc1,           // A1
  input wire logic [31:0] y_index_step,   // Y step
  input wire mem_req_type x_req,          // X request
  input wire mem_req_type y_req,          // Y request
  input wire logic [31:0] ptr4,           // R4
  input wire logic [31:0] ptr7,           // R7
  input wire logic [31:0] x0_reg,         // X0
  input wire logic        condition_flag  // Flag
);
  logic [15:0] op_q;
  logic        v_q;
  always_ff @(posedge clk) begin
    op_q <= opcode;
    v_q  <= opcode_valid;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  // ==========================================================
  a_x_take: assert property (x_req.valid == (v_q &&
    op_q[15:10] == SLOT_PREFIX && op_q[3:2] != 2'h0)) else $error("x take");
  a_y_take: assert property (y_req.valid == (v_q &&
    op_q[15:10] == SLOT_PREFIX && op_q[1:0] != 2'h0)) else $error("y take");
  a_x_dir: assert property (x_req.valid |->
    x_req.write == op_q[5]) else $error("x direction");
  a_x_inc: assert property (x_req.valid && op_q[3:2] == 2'h2 &&
    !op_q[9] |-> ptr4 == x_req.addr + PTR_STEP) else $error("x step");
  a_y_index: assert property (y_req.valid && op_q[1:0] == 2'h3 &&
    op_q[8] |-> ptr7 == y_req.addr + $past(y_index_step))
    else $error("y index");
  a_x_fill: assert property (x_req.valid && !x_req.write &&
    !op_q[7] |=> x0_reg == {$past(x_rdata), LOW_ZERO}) else $error("x fill");
  a_x_store: assert property (x_req.valid && x_req.write |->
    x_req.wdata == (op_q[7] ? $past(acc1[31:16]) : $past(acc0[31:16])))
    else $error("x store data");
  a_flag_hold: assert property (opcode_valid |=>
    $stable(condition_flag)) else $error("flag moved");
  a_plain_keep: assert property (x_req.valid && op_q[3:2] == 2'h1 &&
    !op_q[9] |-> $stable(ptr4)) else $error("plain moved");
  c_x_load: cover property (x_req.valid && !x_req.write);
  c_y_store: cover property (y_req.valid && y_req.write);
  c_both: cover property (x_req.valid && y_req.valid);
endmodule : xy_slot_chk

bind dsp_xy_memory_transfer xy_slot_chk xy_slot_chk_i (
  .clk(clk), .rst(rst), .opcode(opcode), .opcode_valid(opcode_valid),
  .x_rdata(x_rdata), .acc0(acc0), .acc1(acc1), .y_index_step(y_index_step),
  .x_req(x_req), .y_req(y_req), .ptr4(ptr4), .ptr7(ptr7), .x0_reg(x0_reg),
  .condition_flag(condition_flag)
);

// *** xy_mem_model.sv ***
// Model of the X and Y data memories
`timescale 1ns/1ns
module xy_mem_model
  import xy_transfer_pkg::*;
(
  input  wire logic         clk,     // Clock
  input  wire mem_req_type  x_req,   // X request
  input  wire mem_req_type  y_req,   // Y request
  output logic [WORD_W-1:0] x_rdata, // X read data
  output logic [WORD_W-1:0] y_rdata  // Y read data
);
  logic [WORD_W-1:0] x_last_q = 16'h0000;
  logic [WORD_W-1:0] y_last_q = 16'h0000;
  // Idle lines toggle so a late sample never sees stale data
  always_comb begin
    x_rdata = ~x_last_q;
    y_rdata = ~y_last_q;
    if (x_req.valid && !x_req.write) x_rdata = x_req.addr[15:0] ^ 16'ha5c3;
    if (y_req.valid && !y_req.write) y_rdata = y_req.addr[15:0] ^ 16'ha5c3;
  end
  always_ff @(posedge clk) begin
    x_last_q <= x_rdata;
    y_last_q <= y_rdata;
  end
endmodule : xy_mem_model

// *** dsp_xy_memory_transfer_test.sv ***
// Self-checking bench for the X and Y transfer slots
`timescale 1ns/1ns
module dsp_xy_memory_transfer_test
  import xy_transfer_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [15:0]   opcode = 16'h0000;
  logic          opcode_valid = 1'b0;
  logic [15:0]   x_rdata, y_rdata;
  logic [31:0]   acc0 = 32'h1234_5678;
  logic [31:0]   acc1 = 32'h9abc_def0;
  logic [31:0]   x_index_step = 32'h0000_0010;
  logic [31:0]   y_index_step = 32'h0000_0020;
  logic          flag_in = 1'b1;
  mem_req_type   x_req, y_req;
  logic [31:0]   ptr4, ptr5, ptr6, ptr7;
  logic [31:0]   x0_reg, x1_reg, y0_reg, y1_reg;
  logic          condition_flag;
  int            err_total = 0;
  int            n_compared = 0;

  dsp_xy_memory_transfer dsp_xy_memory_transfer_i (
    .clk(clk), .rst(rst), .opcode(opcode), .opcode_valid(opcode_valid),
    .x_rdata(x_rdata), .y_rdata(y_rdata), .acc0(acc0), .acc1(acc1),
    .x_index_step(x_index_step), .y_index_step(y_index_step),
    .flag_in(flag_in), .x_req(x_req), .y_req(y_req), .ptr4(ptr4),
    .ptr5(ptr5), .ptr6(ptr6), .ptr7(ptr7), .x0_reg(x0_reg),
    .x1_reg(x1_reg), .y0_reg(y0_reg), .y1_reg(y1_reg),
    .condition_flag(condition_flag));
  xy_mem_model xy_mem_model_i (.clk(clk), .x_req(x_req), .y_req(y_req),
    .x_rdata(x_rdata), .y_rdata(y_rdata));

  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] mk(input logic [5:0] f,
                                     input logic [1:0] mx, my);
    return {6'h3c, f, mx, my};
  endfunction : mk
  function automatic logic [31:0] ld(input logic [31:0] a);
    return {a[15:0] ^ 16'ha5c3, 16'h0000};
  endfunction : ld
  // Leaves the bench half a cycle after the take, request showing
  task automatic issue(input logic [15:0] op);
    @(negedge clk);
    opcode = op;
    opcode_valid = 1'b1;
    @(negedge clk);
    opcode_valid = 1'b0;
  endtask : issue
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_x_slot;
    issue(mk(6'h00, 2'h2, 2'h0));
    chk(32'({x_req.valid, x_req.write, y_req.valid}), 32'h4);
    chk(x_req.addr, 32'h0);
    chk(ptr4, 32'h2);
    @(negedge clk);
    chk(x0_reg, ld(32'h0));
    issue(mk(6'h28, 2'h3, 2'h0));
    issue(mk(6'h28, 2'h3, 2'h0));
    chk(x_req.addr, 32'h10);
    chk(ptr5, 32'h20);
    @(negedge clk);
    chk(x1_reg, ld(32'h10));
    issue(mk(6'h0a, 2'h1, 2'h0));
    chk(32'({x_req.write, x_req.wdata}), 32'h19abc);
    chk(ptr4, 32'h2);
    $display("t_x_slot done");
  endtask : t_x_slot
  task automatic t_y_slot;
    issue(mk(6'h11, 2'h0, 2'h3));
    chk(32'({x_req.valid, y_req.write, y_req.wdata}), 32'h11234);
    chk(ptr7, 32'h20);
    issue(mk(6'h14, 2'h0, 2'h1));
    chk(y_req.addr, 32'h20);
    @(negedge clk);
    chk(y1_reg, ld(32'h20));
    chk(ptr7, 32'h20);
    issue(mk(6'h05, 2'h0, 2'h2));
    chk(32'(y_req.wdata), 32'h9abc);
    chk(ptr6, 32'h2);
    $display("t_y_slot done");
  endtask : t_y_slot
  task automatic t_back;
    @(negedge clk);
    opcode = mk(6'h00, 2'h2, 2'h2);
    opcode_valid = 1'b1;
    @(negedge clk);
    chk(x_req.addr + y_req.addr, 32'h4);
    @(negedge clk);
    opcode_valid = 1'b0;
    chk(x_req.addr, 32'h4);
    chk(ptr6, 32'h6);
    chk(y0_reg, ld(32'h2));
    @(negedge clk);
    chk(x0_reg, ld(32'h4));
    $display("t_back done");
  endtask : t_back
  task automatic t_refuse;
    @(negedge clk);
    opcode = mk(6'h3f, 2'h0, 2'h0);
    opcode_valid = 1'b1;
    flag_in = 1'b0;
    @(negedge clk);
    chk(32'({x_req.valid, y_req.valid, condition_flag}), 32'h1);
    opcode = 16'hf40a;
    @(negedge clk);
    chk(32'({x_req.valid, y_req.valid}), 32'h0);
    opcode_valid = 1'b0;
    opcode = mk(6'h00, 2'h2, 2'h2);
    @(negedge clk);
    chk(32'({x_req.valid, y_req.valid, condition_flag}), 32'h0);
    chk(ptr4 + ptr6, 32'hc);
    $display("t_refuse done");
  endtask : t_refuse

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t run hung", $time);
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk(ptr4 | ptr7 | x0_reg | y1_reg, 32'h0);
    t_x_slot();
    t_y_slot();
    t_back();
    t_refuse();
    complete_run();
  end
endmodule : dsp_xy_memory_transfer_test
